// ==== inc/mcel_pkg.sv ====
// Package for the machine-check error logging block: offsets, codes, event layout
package mcel_pkg;

   // Register byte offsets (64-bit status split into two words, plus control and event count)
   localparam logic [7:0]  MCEL_STATUS_LO_OFF   = 8'h00;
   localparam logic [7:0]  MCEL_STATUS_HI_OFF   = 8'h04;
   localparam logic [7:0]  MCEL_CTRL_OFF        = 8'h08;
   localparam logic [7:0]  MCEL_EVCNT_OFF       = 8'h0C;

   // Field positions inside the 64-bit status
   localparam int          MCEL_TYPE_LSB        = 0;
   localparam int          MCEL_SUB_LSB         = 16;
   localparam int          MCEL_OTHER_LSB       = 32;
   localparam int          MCEL_OTHER_W         = 25;

   // Reset values
   localparam logic [63:0] MCEL_STATUS_RST      = 64'h0000_0000_0000_0000;
   localparam logic [24:0] MCEL_OTHER_RST       = 25'h000_0000;

   // Error type codes (the only two ever logged; reset and clear load zero)
   localparam logic [15:0] MCEL_TYPE_INTERNAL   = 16'h0400;
   localparam logic [15:0] MCEL_TYPE_BUS        = 16'h0E0F;

   // Bus and interconnect sub-code bit positions
   localparam int          MCEL_BUS_REQ_PAR     = 16;
   localparam int          MCEL_BUS_HARD_FAIL   = 20;
   localparam int          MCEL_BUS_RSP_PAR     = 21;
   localparam int          MCEL_BUS_DATA_PAR    = 22;
   localparam logic [15:0] MCEL_BUS_SUB_MASK    = 16'h0071;

   // Internal controller sub-codes
   localparam logic [15:0] MCEL_SC_INCL_C0      = 16'h0001;
   localparam logic [15:0] MCEL_SC_INCL_C1      = 16'h0002;
   localparam logic [15:0] MCEL_SC_WEXCL_C0     = 16'h0003;
   localparam logic [15:0] MCEL_SC_WEXCL_C1     = 16'h0004;
   localparam logic [15:0] MCEL_SC_INCL_BUS     = 16'h0005;
   localparam logic [15:0] MCEL_SC_SNOOP_STALL  = 16'h0006;
   localparam logic [15:0] MCEL_SC_WR_STALL     = 16'h0007;
   localparam logic [15:0] MCEL_SC_ARB_TMO      = 16'h0008;
   localparam logic [15:0] MCEL_SC_INCL_C2      = 16'h000A;
   localparam logic [15:0] MCEL_SC_WEXCL_C2     = 16'h000B;
   localparam logic [15:0] MCEL_SC_INT_TMO_A    = 16'h0200;
   localparam logic [15:0] MCEL_SC_INT_TMO_B    = 16'h0300;
   localparam logic [15:0] MCEL_SC_QUEUE_FULL   = 16'h0400;
   localparam logic [15:0] MCEL_SC_QUIET_TMO    = 16'h0500;
   localparam logic [15:0] MCEL_SC_CECC_C0      = 16'hC002;
   localparam logic [15:0] MCEL_SC_CECC_C1      = 16'hC004;
   localparam logic [15:0] MCEL_SC_CECC_C2      = 16'hC008;
   localparam logic [15:0] MCEL_SC_UECC_C0      = 16'hE002;
   localparam logic [15:0] MCEL_SC_UECC_C1      = 16'hE004;
   localparam logic [15:0] MCEL_SC_UECC_C2      = 16'hE008;

   // Internal event index, one pulse input bit each
   localparam int          MCEL_NUM_INT         = 20;
   localparam int          MCEL_EV_QUIET        = 13;

   // Control register bits
   localparam int          MCEL_CTRL_EN         = 0;
   localparam int          MCEL_CTRL_OVWR       = 1;
   localparam logic [1:0]  MCEL_CTRL_RST        = 2'h1;

   // AXI4-Lite responses
   localparam logic [1:0]  MCEL_RESP_OKAY       = 2'h0;
   localparam logic [1:0]  MCEL_RESP_SLVERR     = 2'h2;

   // Bus error event carrier
   typedef struct packed {
      logic req_par;
      logic hard_fail;
      logic rsp_par;
      logic data_par;
   } mcel_bus_ev_t;

   // Write-path states
   typedef enum logic [2:0] {
      MCEL_W_IDLE = 3'b001,
      MCEL_W_RESP = 3'b010,
      MCEL_W_SPARE = 3'b100
   } mcel_wstate_t;

endpackage : mcel_pkg

// ==== rtl/mcel_top.sv ====
// Machine-check error status log for the cache, bus and bus controller
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns

module mcel_top
   import mcel_pkg::*;
(
   input  wire logic                      clk_i,
   input  wire logic                      rst_b_i,
   // Error event pulses from inside the processor
   input  wire logic [MCEL_NUM_INT-1:0]   int_ev_i,
   input  wire mcel_bus_ev_t              bus_ev_i,
   // AXI4-Lite slave
   input  wire logic [7:0]                s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [7:0]                s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // Log holds an event
   output logic                           log_valid_o
);

   // Internal sub-code table, indexed by event bit (lowest index wins)
   localparam logic [15:0] SC_TABLE [MCEL_NUM_INT] = '{
      MCEL_SC_INCL_C0, MCEL_SC_INCL_C1, MCEL_SC_INCL_C2, MCEL_SC_INCL_BUS,
      MCEL_SC_WEXCL_C0, MCEL_SC_WEXCL_C1, MCEL_SC_WEXCL_C2,
      MCEL_SC_SNOOP_STALL, MCEL_SC_WR_STALL, MCEL_SC_ARB_TMO,
      MCEL_SC_INT_TMO_A, MCEL_SC_INT_TMO_B, MCEL_SC_QUEUE_FULL,
      MCEL_SC_QUIET_TMO,
      MCEL_SC_CECC_C0, MCEL_SC_CECC_C1, MCEL_SC_CECC_C2,
      MCEL_SC_UECC_C0, MCEL_SC_UECC_C1, MCEL_SC_UECC_C2
   };

   logic [15:0]            log_type;
   logic [15:0]            log_sub;
   logic [24:0]            corr_count;
   logic                   log_full;
   logic [1:0]             ctrl;
   mcel_wstate_t           wstate;
   logic                   aw_held;
   logic                   w_held;
   logic [7:0]             aw_addr;
   logic [31:0]            w_data;
   logic [3:0]             w_strb;

   // Priority pick of the internal event; loop keeps table and index aligned
   logic [15:0]            int_code;
   logic                   int_any;
   logic                   quiet_hit;
   always_comb begin
      int_code = 16'h0000;
      int_any  = 1'b0;
      for (int i = MCEL_NUM_INT - 1; i >= 0; i--) begin
         if (int_ev_i[i]) begin
            int_code = SC_TABLE[i];
            int_any  = 1'b1;
         end
      end
   end
   assign quiet_hit = int_ev_i[MCEL_EV_QUIET];

   // Correctable events: quiet timeout and correctable ECC
   wire       corr_ev   = quiet_hit | (|int_ev_i[16:14]);
   wire       bus_any   = bus_ev_i.req_par | bus_ev_i.hard_fail
                        | bus_ev_i.rsp_par | bus_ev_i.data_par;
   wire [15:0] bus_code = {9'h000, bus_ev_i.data_par, bus_ev_i.rsp_par,
                           bus_ev_i.hard_fail, 3'h0, bus_ev_i.req_par};

   // Bus errors take precedence: they arrive from outside the die
   wire        ev_any    = ctrl[MCEL_CTRL_EN] & (bus_any | int_any);
   wire        can_log   = ~log_full | ctrl[MCEL_CTRL_OVWR];
   wire        do_log    = ev_any & can_log;
   wire [15:0] next_type = bus_any ? MCEL_TYPE_BUS : MCEL_TYPE_INTERNAL;
   wire [15:0] next_sub  = bus_any ? bus_code : int_code;

   // Write decode
   wire        wr_fire   = aw_held & w_held & (wstate == MCEL_W_IDLE);
   wire        wr_lo     = wr_fire & (aw_addr == MCEL_STATUS_LO_OFF);
   wire        wr_hi     = wr_fire & (aw_addr == MCEL_STATUS_HI_OFF);
   wire        wr_ctrl   = wr_fire & (aw_addr == MCEL_CTRL_OFF);
   wire        wr_ok     = wr_lo | wr_hi | wr_ctrl | (aw_addr == MCEL_EVCNT_OFF);
   // Writing zero to the low word with byte 0 enabled clears the log
   wire        sw_clear  = wr_lo & w_strb[0] & (w_data[15:0] == 16'h0000);

   // Log register: hardware set beats software clear
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         log_type <= MCEL_STATUS_RST[15:0];
         log_sub  <= MCEL_STATUS_RST[31:16];
         log_full <= 1'b0;
      end else if (do_log) begin
         log_type <= next_type;
         log_sub  <= next_sub;
         log_full <= 1'b1;
      end else if (sw_clear) begin
         log_type <= MCEL_STATUS_RST[15:0];
         log_sub  <= MCEL_STATUS_RST[31:16];
         log_full <= 1'b0;
      end
   end

   // Correctable event count saturates rather than wrapping
   wire        cnt_sat   = &corr_count;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         corr_count <= MCEL_OTHER_RST;
      end else if (ctrl[MCEL_CTRL_EN] & corr_ev & ~cnt_sat) begin
         corr_count <= corr_count + 25'h000_0001;
      end else if (wr_hi & w_strb[0] & (w_data == 32'h0000_0000)) begin
         corr_count <= MCEL_OTHER_RST;
      end
   end

   // Control register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl <= MCEL_CTRL_RST;
      end else if (wr_ctrl & w_strb[0]) begin
         ctrl <= w_data[1:0];
      end
   end

   // AXI write address and data capture, either order
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response state
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wstate      <= MCEL_W_IDLE;
         s_axi_bresp <= MCEL_RESP_OKAY;
      end else begin
         case (wstate)
            MCEL_W_IDLE: begin
               if (wr_fire) begin
                  wstate      <= MCEL_W_RESP;
                  s_axi_bresp <= wr_ok ? MCEL_RESP_OKAY : MCEL_RESP_SLVERR;
               end
            end
            MCEL_W_RESP: begin
               if (s_axi_bready) begin
                  wstate <= MCEL_W_IDLE;
               end
            end
            default: wstate <= MCEL_W_IDLE;
         endcase
      end
   end

   assign s_axi_awready = ~aw_held & (wstate == MCEL_W_IDLE);
   assign s_axi_wready  = ~w_held & (wstate == MCEL_W_IDLE);
   assign s_axi_bvalid  = (wstate == MCEL_W_RESP);

   // Read mux
   logic [31:0]            rd_word;
   logic                   rd_ok;
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      case (s_axi_araddr)
         MCEL_STATUS_LO_OFF: rd_word = {log_sub, log_type};
         MCEL_STATUS_HI_OFF: rd_word = {7'h00, corr_count};
         MCEL_CTRL_OFF:      rd_word = {29'h0, log_full, ctrl};
         MCEL_EVCNT_OFF:     rd_word = {7'h00, corr_count};
         default:            rd_ok   = 1'b0;
      endcase
   end

   // Read channel: one outstanding read, data from flip-flops
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= MCEL_RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_ok ? MCEL_RESP_OKAY : MCEL_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign s_axi_arready = ~s_axi_rvalid;
   assign log_valid_o   = log_full;

   // Checks
   type_legal_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      log_full |-> (log_type == MCEL_TYPE_BUS || log_type == MCEL_TYPE_INTERNAL))
      else $error("illegal type code logged");
   type_reserved_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      log_type[15:8] != 8'h0F && log_type[11:9] != 3'b100 && log_type[11:9] != 3'b101
         && log_type[11:9] != 3'b110)
      else $error("reserved type code logged");
   bus_type_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      do_log && bus_any |=> log_type == MCEL_TYPE_BUS)
      else $error("bus error not typed as bus");
   int_type_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      do_log && !bus_any |=> log_type == MCEL_TYPE_INTERNAL)
      else $error("internal error mistyped");
   bus_reserved_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      log_type == MCEL_TYPE_BUS |-> (log_sub & ~MCEL_BUS_SUB_MASK) == 16'h0000)
      else $error("reserved bus sub-code bit set");
   bus_bits_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      do_log && bus_any |=> log_sub[MCEL_BUS_REQ_PAR-16] == $past(bus_ev_i.req_par)
         && log_sub[MCEL_BUS_HARD_FAIL-16] == $past(bus_ev_i.hard_fail)
         && log_sub[MCEL_BUS_RSP_PAR-16] == $past(bus_ev_i.rsp_par)
         && log_sub[MCEL_BUS_DATA_PAR-16] == $past(bus_ev_i.data_par))
      else $error("bus sub-code bits wrong");
   quiet_code_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      do_log && !bus_any && int_ev_i == 20'h02000 |=> log_sub == MCEL_SC_QUIET_TMO)
      else $error("quiet timeout code wrong");
   ecc_code_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      do_log && !bus_any && int_ev_i == 20'h20000 |=> log_sub == MCEL_SC_UECC_C0)
      else $error("uncorrectable ecc code wrong");
   incl_code_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      do_log && !bus_any && int_ev_i[0] |=> log_sub == MCEL_SC_INCL_C0)
      else $error("inclusion code wrong");
   log_stable_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      log_full && !ctrl[MCEL_CTRL_OVWR] && !sw_clear |=> $stable(log_sub)
         && $stable(log_type))
      else $error("logged fields changed while held");
   count_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ctrl[MCEL_CTRL_EN] && corr_ev && !cnt_sat |=> corr_count == $past(corr_count) + 25'h1)
      else $error("correctable count did not step");

   // Both write halves held start one response; nothing more taken meanwhile
   sequence wr_pair_s;
      aw_held && w_held && (wstate == MCEL_W_IDLE);
   endsequence

   sequence wr_answer_s;
      s_axi_bvalid && !s_axi_awready && !s_axi_wready;
   endsequence

   wr_resp_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_pair_s |=> wr_answer_s)
      else $error("write response missing");

   // Response must stand until the master takes it, or a write is lost
   bresp_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");

   // Read data stands with rvalid until taken
   sequence rd_wait_s;
      s_axi_rvalid && !s_axi_rready;
   endsequence

   rdata_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      rd_wait_s |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped early");

   // One read at a time: no new address while data is pending
   rd_single_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");

   // Low word read returns sub-code and type of the same event
   rd_status_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_axi_arvalid && s_axi_arready && (s_axi_araddr == MCEL_STATUS_LO_OFF)
      |=> s_axi_rdata == {$past(log_sub), $past(log_type)})
      else $error("status read does not match log");

   // Every logged event raises the valid flag
   log_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      do_log |=> log_full && log_valid_o)
      else $error("event logged without valid flag");

   // Software clear empties the log unless an event lands in that cycle
   log_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      sw_clear && !do_log |=> !log_full && (log_type == MCEL_STATUS_RST[15:0]))
      else $error("log not cleared");

   // Set beats clear: an event in the clear cycle must survive
   set_wins_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      sw_clear && do_log |=> log_full)
      else $error("clear beat a new event");

   // With logging off nothing new is recorded
   log_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !ctrl[MCEL_CTRL_EN] && !sw_clear |=> $stable(log_full) && $stable(log_sub))
      else $error("event logged while disabled");

   // Saturated count stays put until software clears it
   count_sat_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      cnt_sat && !wr_hi |=> cnt_sat)
      else $error("correctable count wrapped");

   // Count moves only on a correctable event or a clear
   count_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !corr_ev && !wr_hi |=> $stable(corr_count))
      else $error("correctable count moved without event");

   // Bits above the other-information field read as zero
   hi_word_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_axi_arvalid && s_axi_arready && (s_axi_araddr == MCEL_STATUS_HI_OFF)
      |=> s_axi_rdata[31:25] == 7'h00)
      else $error("high word reserved bits set");

   // Per-event sub-code: the lowest pending internal event owns the log
   for (genvar g = 0; g < MCEL_NUM_INT; g++) begin : g_sub_chk
      localparam logic [MCEL_NUM_INT-1:0] LOW_MASK = ~({MCEL_NUM_INT{1'b1}} << g);
      int_code_a: assert property (
         @(posedge clk_i) disable iff (!rst_b_i)
         do_log && !bus_any && int_ev_i[g] && ((int_ev_i & LOW_MASK) == '0)
         |=> log_sub == SC_TABLE[g])
         else $error("internal sub-code wrong");
   end

   // Bus flag wins even with internal events pending
   bus_first_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      do_log && bus_any && int_any |=> log_type == MCEL_TYPE_BUS && log_sub == $past(bus_code))
      else $error("internal event beat a bus error");

   // Quiet timeout is correctable: it must bump the count when enabled
   quiet_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ctrl[MCEL_CTRL_EN] && quiet_hit && !cnt_sat |=> corr_count != $past(corr_count))
      else $error("quiet timeout not counted");

   // Unmapped writes are refused with an error response
   wr_refuse_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      wr_fire && !wr_ok |=> s_axi_bresp == MCEL_RESP_SLVERR)
      else $error("unmapped write not refused");

   // Unmapped reads are refused likewise
   rd_refuse_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      s_axi_arvalid && s_axi_arready && !rd_ok |=> s_axi_rresp == MCEL_RESP_SLVERR)
      else $error("unmapped read not refused");

endmodule : mcel_top

// ==== sim/test_machine_check_error_logging.sv ====
// Self-checking bench for the machine-check error log over AXI4-Lite
`timescale 1ns/1ns
module test_machine_check_error_logging
   import mcel_pkg::*;
;
   logic                    clk_i = 1'b0;
   logic                    rst_b_i = 1'b0;
   logic [MCEL_NUM_INT-1:0] int_ev_i = '0;
   mcel_bus_ev_t            bus_ev_i = '0;
   logic [7:0]              s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic                    s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic                    s_axi_bready = 1'b0, s_axi_rready = 1'b0;
   logic [31:0]             s_axi_wdata = 32'h0000_0000;
   logic [3:0]              s_axi_wstrb = 4'h0;
   logic                    s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic                    s_axi_rvalid, log_valid_o;
   logic [1:0]              s_axi_bresp, s_axi_rresp;
   logic [31:0]             s_axi_rdata;
   int                      bad_count = 0;
   int                      check_count = 0;
   // Sub-codes in event index order
   logic [15:0] subs [MCEL_NUM_INT] = '{MCEL_SC_INCL_C0, MCEL_SC_INCL_C1, MCEL_SC_INCL_C2,
      MCEL_SC_INCL_BUS, MCEL_SC_WEXCL_C0, MCEL_SC_WEXCL_C1, MCEL_SC_WEXCL_C2,
      MCEL_SC_SNOOP_STALL, MCEL_SC_WR_STALL, MCEL_SC_ARB_TMO, MCEL_SC_INT_TMO_A,
      MCEL_SC_INT_TMO_B, MCEL_SC_QUEUE_FULL, MCEL_SC_QUIET_TMO, MCEL_SC_CECC_C0,
      MCEL_SC_CECC_C1, MCEL_SC_CECC_C2, MCEL_SC_UECC_C0, MCEL_SC_UECC_C1, MCEL_SC_UECC_C2};
   // Bus sub-code bits for req_par, hard_fail, rsp_par, data_par
   logic [15:0] bsub [4] = '{16'h0001, 16'h0010, 16'h0020, 16'h0040};
   logic [15:0] ball;

   mcel_top i_mcel_top (.clk_i, .rst_b_i, .int_ev_i, .bus_ev_i, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .log_valid_o);

   // 20 MHz clock
   always #25 clk_i = ~clk_i;

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Handshakes judged just before the edge, acted on right after it
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic aw_hs, w_hs, b_hs;
      logic [1:0] r;
      s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      b_hs = 1'b0;
      while (!b_hs) begin
         @(negedge clk_i);
         aw_hs = s_axi_awvalid & s_axi_awready;
         w_hs = s_axi_wvalid & s_axi_wready;
         b_hs = s_axi_bvalid & s_axi_bready;
         r = s_axi_bresp;
         @(posedge clk_i);
         if (aw_hs) s_axi_awvalid <= 1'b0;
         if (w_hs) s_axi_wvalid <= 1'b0;
         if (b_hs) s_axi_bready <= 1'b0;
      end
      chk("bresp", {30'h0, er}, {30'h0, r});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic ar_hs, r_hs;
      logic [31:0] d;
      logic [1:0] r;
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      r_hs = 1'b0;
      while (!r_hs) begin
         @(negedge clk_i);
         ar_hs = s_axi_arvalid & s_axi_arready;
         r_hs = s_axi_rvalid & s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk_i);
         if (ar_hs) s_axi_arvalid <= 1'b0;
         if (r_hs) s_axi_rready <= 1'b0;
      end
      chk("rresp", {30'h0, er}, {30'h0, r});
      if (er === MCEL_RESP_OKAY) chk("rdata", exp, d);
   endtask : rd

   // One-cycle event pulse on both sources
   task automatic pulse(input logic [MCEL_NUM_INT-1:0] iv, input logic [3:0] bv);
      @(posedge clk_i);
      int_ev_i <= iv;
      bus_ev_i <= mcel_bus_ev_t'(bv);
      @(posedge clk_i);
      int_ev_i <= '0;
      bus_ev_i <= '0;
      @(posedge clk_i);
   endtask : pulse

   task automatic clr();
      wr(MCEL_STATUS_LO_OFF, 32'h0000_0000, 4'h1, MCEL_RESP_OKAY);
   endtask : clr

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   // Watchdog, well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      wrap_up();
   end

   initial begin
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      rd(MCEL_STATUS_LO_OFF, 32'h0, MCEL_RESP_OKAY);
      rd(MCEL_STATUS_HI_OFF, 32'h0, MCEL_RESP_OKAY);
      rd(MCEL_CTRL_OFF, 32'h1, MCEL_RESP_OKAY);
      chk("log_valid", 32'h0, {31'h0, log_valid_o});
      $display("test reset done");
      // Every internal code, cleared between events
      for (int i = 0; i < MCEL_NUM_INT; i++) begin
         pulse(20'h00001 << i, 4'h0);
         chk("log_valid", 32'h1, {31'h0, log_valid_o});
         rd(MCEL_STATUS_LO_OFF, {subs[i], 16'h0400}, MCEL_RESP_OKAY);
         clr();
      end
      // Quiet timeout and three correctable ECC events counted
      rd(MCEL_STATUS_HI_OFF, 32'h4, MCEL_RESP_OKAY);
      rd(MCEL_EVCNT_OFF, 32'h4, MCEL_RESP_OKAY);
      wr(MCEL_STATUS_HI_OFF, 32'h0, 4'hF, MCEL_RESP_OKAY);
      rd(MCEL_STATUS_HI_OFF, 32'h0, MCEL_RESP_OKAY);
      $display("test internal codes done");
      // Each bus flag alone, then all together
      ball = 16'h0000;
      for (int b = 0; b < 4; b++) begin
         pulse('0, 4'b1000 >> b);
         rd(MCEL_STATUS_LO_OFF, {bsub[b], 16'h0E0F}, MCEL_RESP_OKAY);
         ball = ball | bsub[b];
         clr();
      end
      pulse('0, 4'hF);
      rd(MCEL_STATUS_LO_OFF, {ball, 16'h0E0F}, MCEL_RESP_OKAY);
      clr();
      $display("test bus codes done");
      // Bus event wins over a same-cycle internal one
      pulse(20'h00001, 4'h1);
      rd(MCEL_STATUS_LO_OFF, {16'h0040, 16'h0E0F}, MCEL_RESP_OKAY);
      clr();
      // Full log holds its first event until overwrite is enabled
      pulse(20'h00001, 4'h0);
      rd(MCEL_CTRL_OFF, 32'h5, MCEL_RESP_OKAY);
      pulse(20'h01000, 4'h0);
      rd(MCEL_STATUS_LO_OFF, {MCEL_SC_INCL_C0, 16'h0400}, MCEL_RESP_OKAY);
      wr(MCEL_CTRL_OFF, 32'h3, 4'hF, MCEL_RESP_OKAY);
      pulse(20'h01000, 4'h0);
      rd(MCEL_STATUS_LO_OFF, {MCEL_SC_QUEUE_FULL, 16'h0400}, MCEL_RESP_OKAY);
      wr(MCEL_CTRL_OFF, 32'h1, 4'hF, MCEL_RESP_OKAY);
      clr();
      chk("log_valid", 32'h0, {31'h0, log_valid_o});
      $display("test hold and overwrite done");
      // Unmapped address is refused without effect
      rd(8'h10, 32'h0, MCEL_RESP_SLVERR);
      wr(8'h10, 32'hFFFF_FFFF, 4'hF, MCEL_RESP_SLVERR);
      rd(MCEL_STATUS_LO_OFF, 32'h0, MCEL_RESP_OKAY);
      $display("test unmapped done");
      wrap_up();
   end
endmodule : test_machine_check_error_logging
